// ### design/ebm_pkg.sv
// Purpose : Shared types and constants of the external bus pin multiplexer.
// Assumes : One clock (clk, 200 MHz), synchronous active-high reset.
// Notes   : Offsets of address fields into the external pins are kept here.
package ebm_pkg;

    // ****************************************************************
    // Constants
    // ****************************************************************
    localparam int         FIFO_DEPTH   = 8;
    localparam int         PTR_W        = 3;
    localparam logic       OWNER_STATIC = 1'h0;
    localparam logic       OWNER_DRAM   = 1'h1;
    localparam int         DRAM_LO_POS  = 2;    // Pins 11..2 from DRAM bits 9..0
    localparam int         DRAM_HI_POS  = 13;   // Pins 14..13 from DRAM bits 12..11
    localparam int         BANK_POS     = 16;   // Bank selects share pins 17..16
    localparam int         CS_DRAM_IDX  = 1;
    localparam int         CS_NAND_IDX  = 3;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_STATIC, ST_DRAM} ebm_state_t;

    // One pin-cycle of an access, as queued by either controller
    typedef struct packed {
        logic        owner;
        logic        last;
        logic [25:0] smc_addr;
        logic [12:0] dram_addr;
        logic [1:0]  dram_bank;
        logic [31:0] wdata;
        logic        drive;
        logic [7:0]  cs_n;
        logic [3:0]  wr_n;
        logic        rd_n;
        logic        dram_cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        sdwe_n;
        logic        cke;
        logic [3:0]  bm_n;
        logic [1:0]  card_ce_n;
        logic        card_io_rd_n;
        logic        card_io_wr_n;
        logic        card_rnw;
    } ebm_word_t;

    typedef struct packed {
        logic [25:0] addr;
        logic        dram_addr_ten_pin;
        logic [31:0] data_out;
        logic        data_oe_n;
        logic [7:0]  chip_select_n;
        logic [3:0]  write_strobe_n;
        logic        read_strobe_n;
        logic        write_enable_n;
        logic        dram_chip_select_n;
        logic        ras_n;
        logic        cas_n;
        logic        dram_we_n;
        logic        dram_clock_enable;
        logic [1:0]  card_chip_enable_n;
        logic        card_io_read_n;
        logic        card_io_write_n;
        logic        card_read_not_write;
        logic        nand_select_n;
        logic        nand_out_enable_n;
        logic        nand_write_enable_n;
    } ebm_pins_t;

    localparam ebm_pins_t PINS_IDLE = '{
        addr: 26'h0, dram_addr_ten_pin: 1'h0, data_out: 32'h0, data_oe_n: 1'h1,
        chip_select_n: 8'hFF, write_strobe_n: 4'hF, read_strobe_n: 1'h1,
        write_enable_n: 1'h1, dram_chip_select_n: 1'h1, ras_n: 1'h1, cas_n: 1'h1,
        dram_we_n: 1'h1, dram_clock_enable: 1'h1, card_chip_enable_n: 2'h3,
        card_io_read_n: 1'h1, card_io_write_n: 1'h1, card_read_not_write: 1'h1,
        nand_select_n: 1'h1, nand_out_enable_n: 1'h1, nand_write_enable_n: 1'h1};

endpackage : ebm_pkg

// ### design/ebm_fifo.sv
// Purpose : Synchronous FIFO with valid/ready on both sides.
// Assumes : Single clock, synchronous active-high reset.
// Notes   : Full and empty are registered so ready and valid leave flops.
`timescale 1ns/1ps
module ebm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int PTR_W = 3
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0]            wptr;
        logic [PTR_W-1:0]            rptr;
        logic [PTR_W:0]              count;
        logic                        not_full;
        logic                        not_empty;
    } ebm_fifo_state_t;

    ebm_fifo_state_t state_reg;
    ebm_fifo_state_t state_next;
    logic            push;
    logic            pop;

    assign push      = in_valid && state_reg.not_full;
    assign pop       = out_ready && state_reg.not_empty;
    assign in_ready  = state_reg.not_full;
    assign out_valid = state_reg.not_empty;
    assign out_data  = state_reg.mem[state_reg.rptr];

    always_comb
    begin
        state_next = state_reg;
        if (push)
        begin
            state_next.mem[state_reg.wptr] = in_data;
            state_next.wptr                = state_reg.wptr + 1'b1;
        end
        if (pop)
            state_next.rptr = state_reg.rptr + 1'b1;
        state_next.count     = state_reg.count + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};
        state_next.not_full  = (state_next.count != (PTR_W+1)'(DEPTH));
        state_next.not_empty = (state_next.count != '0);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg          <= '0;
            state_reg.not_full <= 1'b1;
        end
        else
            state_reg <= state_next;
    end
endmodule : ebm_fifo

// ### design/ebm_pin_mux.sv
// Purpose : Routes static and DRAM controller pin cycles onto shared external pins.
// Assumes : Controllers queue one word per pin cycle; a word marked last ends an access.
// Notes   : Pins, wait and read data all leave flops; inputs from pins are double-synchronised.
//           An owner switch inside an access costs one idle cycle on the pins.
`timescale 1ns/1ps
module ebm_pin_mux (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              cs1_assign_bit,
    input  wire logic              cs3_assign_bit,
    input  wire logic              word_valid,
    output logic                   word_ready,
    input  wire ebm_pkg::ebm_word_t word_in,
    input  wire logic              ext_wait_n,
    input  wire logic [31:0]       data_in,
    output ebm_pkg::ebm_pins_t     ext_pins,
    output logic                   wait_req,
    output logic [31:0]            rd_data,
    output logic                   busy
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        ebm_pkg::ebm_state_t fsm;
        logic                cs1a;
        logic                cs3a;
        ebm_pkg::ebm_pins_t  pins;
        logic [1:0]          wait_sync;
        logic                wait_req;
        logic [31:0]         data_sync1;
        logic [31:0]         rd_data;
        logic                busy;
    } ebm_mux_state_t;

    ebm_mux_state_t    state_reg;
    ebm_mux_state_t    state_next;
    logic              fifo_valid;
    logic              fifo_ready;
    ebm_pkg::ebm_word_t fifo_word;
    logic [$bits(ebm_pkg::ebm_word_t)-1:0] fifo_raw;

    assign fifo_word = ebm_pkg::ebm_word_t'(fifo_raw);

    ebm_fifo #(
        .WIDTH ($bits(ebm_pkg::ebm_word_t)),
        .DEPTH (ebm_pkg::FIFO_DEPTH),
        .PTR_W (ebm_pkg::PTR_W)
    ) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (word_valid),
        .in_ready  (word_ready),
        .in_data   (word_in),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_raw)
    );

    // ****************************************************************
    // Pin mapping
    // ****************************************************************
    function automatic ebm_pkg::ebm_pins_t map_static(input ebm_pkg::ebm_word_t w,
                                                      input logic cs1a,
                                                      input logic cs3a);
        ebm_pkg::ebm_pins_t p;
        p                     = ebm_pkg::PINS_IDLE;
        p.addr                = w.smc_addr;
        p.data_out            = w.wdata;
        p.data_oe_n           = ~w.drive;
        p.chip_select_n       = w.cs_n;
        p.write_strobe_n      = w.wr_n;
        p.read_strobe_n       = w.rd_n;
        p.write_enable_n      = w.wr_n[0];
        // Card pins pass straight through; card glue upstream owns their timing
        p.card_chip_enable_n  = w.card_ce_n;
        p.card_io_read_n      = w.card_io_rd_n;
        p.card_io_write_n     = w.card_io_wr_n;
        p.card_read_not_write = w.card_rnw;
        // Once assigned to DRAM, select 1 is DRAM-owned: the static controller must not reach it
        if (cs1a)
            p.chip_select_n[ebm_pkg::CS_DRAM_IDX] = 1'h1;
        if (cs3a)
        begin
            p.nand_select_n       = w.cs_n[ebm_pkg::CS_NAND_IDX];
            p.nand_out_enable_n   = w.cs_n[ebm_pkg::CS_NAND_IDX] | w.rd_n;
            p.nand_write_enable_n = w.cs_n[ebm_pkg::CS_NAND_IDX] | w.wr_n[0];
        end
        return p;
    endfunction : map_static

    function automatic ebm_pkg::ebm_pins_t map_dram(input ebm_pkg::ebm_word_t w,
                                                    input logic cs1a);
        ebm_pkg::ebm_pins_t p;
        p                                                     = ebm_pkg::PINS_IDLE;
        p.addr[ebm_pkg::DRAM_LO_POS +: 10]                    = w.dram_addr[9:0];
        p.dram_addr_ten_pin                                   = w.dram_addr[10];
        p.addr[ebm_pkg::DRAM_HI_POS +: 2]                     = w.dram_addr[12:11];
        // Bank selects borrow static-only address pins
        p.addr[ebm_pkg::BANK_POS +: 2]                        = w.dram_bank;
        p.data_out                                            = w.wdata;
        p.data_oe_n                                           = ~w.drive;
        p.write_strobe_n[1]                                   = w.bm_n[1];
        p.write_strobe_n[3]                                   = w.bm_n[3];
        p.ras_n                                               = w.ras_n;
        p.cas_n                                               = w.cas_n;
        p.dram_we_n                                           = w.sdwe_n;
        p.dram_clock_enable                                   = w.cke;
        // Without the assignment the DRAM select is never driven active
        p.dram_chip_select_n                                  = w.dram_cs_n | ~cs1a;
        p.chip_select_n[ebm_pkg::CS_DRAM_IDX]                 = w.dram_cs_n | ~cs1a;
        return p;
    endfunction : map_dram

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic stall;
    logic take;
    logic head_is_dram;

    // Owner of the word at the FIFO head picks the mapping
    assign head_is_dram = (fifo_word.owner == ebm_pkg::OWNER_DRAM);

    always_comb
    begin
        state_next            = state_reg;
        // ****************************************************************
        // Pin synchronisers
        // ****************************************************************
        state_next.wait_sync  = {state_reg.wait_sync[0], ext_wait_n};
        state_next.wait_req   = ~state_reg.wait_sync[1];
        state_next.data_sync1 = data_in;
        state_next.rd_data    = state_reg.data_sync1;

        // ****************************************************************
        // Access sequencing
        // ****************************************************************
        // Static access stretched while the synchronised wait is low
        stall = (state_reg.fsm == ebm_pkg::ST_STATIC) && !state_reg.wait_sync[1];
        take  = 1'b0;
        case (state_reg.fsm)
            ebm_pkg::ST_IDLE:
            begin
                state_next.pins = ebm_pkg::PINS_IDLE;
                // Assignment bits follow their inputs only between accesses
                state_next.cs1a = cs1_assign_bit;
                state_next.cs3a = cs3_assign_bit;
                if (fifo_valid)
                begin
                    take = 1'b1;
                    if (head_is_dram)
                    begin
                        state_next.pins = map_dram(fifo_word, cs1_assign_bit);
                        state_next.fsm  = fifo_word.last ? ebm_pkg::ST_IDLE : ebm_pkg::ST_DRAM;
                    end
                    else
                    begin
                        state_next.pins = map_static(fifo_word, cs1_assign_bit, cs3_assign_bit);
                        state_next.fsm  = fifo_word.last ? ebm_pkg::ST_IDLE : ebm_pkg::ST_STATIC;
                    end
                end
            end
            ebm_pkg::ST_STATIC, ebm_pkg::ST_DRAM:
            begin
                // FIFO dry mid-access: pins hold the last word
                if (fifo_valid && !stall)
                begin
                    // Owner change mid-access: close with an idle cycle first
                    if (head_is_dram != (state_reg.fsm == ebm_pkg::ST_DRAM))
                    begin
                        state_next.fsm  = ebm_pkg::ST_IDLE;
                        state_next.pins = ebm_pkg::PINS_IDLE;
                    end
                    else
                    begin
                        take            = 1'b1;
                        state_next.pins = (state_reg.fsm == ebm_pkg::ST_DRAM)
                                          ? map_dram(fifo_word, state_reg.cs1a)
                                          : map_static(fifo_word, state_reg.cs1a, state_reg.cs3a);
                        if (fifo_word.last)
                            state_next.fsm = ebm_pkg::ST_IDLE;
                    end
                end
            end
            default:
            begin
                // Unused encoding falls back to idle pins
                state_next.fsm  = ebm_pkg::ST_IDLE;
                state_next.pins = ebm_pkg::PINS_IDLE;
            end
        endcase
        // Busy also covers the cycle in which a popped last word shows on the pins
        state_next.busy = (state_next.fsm != ebm_pkg::ST_IDLE) || take;
    end

    assign fifo_ready = take;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg           <= '0;
            state_reg.fsm       <= ebm_pkg::ST_IDLE;
            state_reg.pins      <= ebm_pkg::PINS_IDLE;
            // Wait synchroniser starts released so no false stall follows reset
            state_reg.wait_sync <= 2'h3;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Every output is a register field; no logic after the flops
    assign ext_pins = state_reg.pins;
    assign wait_req = state_reg.wait_req;
    assign rd_data  = state_reg.rd_data;
    assign busy     = state_reg.busy;
endmodule : ebm_pin_mux

// ### tb/ebm_pin_mux_properties.sv
// Purpose : Port-level checks of the pin multiplexer.
// Assumes : One clock, synchronous active-high reset.
// Notes   : DRAM ownership is read from the DRAM select pin.
`timescale 1ns/1ps
module ebm_pin_mux_props (
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire logic               ext_wait_n,
    input wire logic [31:0]        data_in,
    input wire ebm_pkg::ebm_pins_t ext_pins,
    input wire logic               wait_req,
    input wire logic [31:0]        rd_data,
    input wire logic               busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ********************************
    // Assertions
    // ********************************
    a_reset_pins_idle: assert property (disable iff (1'b0) sys_rst |=> ext_pins == ebm_pkg::PINS_IDLE && !busy)
        else $error("pins not idle after reset");
    a_wait_low_seen: assert property ((!ext_wait_n) [*4] |-> wait_req)
        else $error("wait request missed");
    a_wait_high_clear: assert property (ext_wait_n [*4] |-> !wait_req)
        else $error("wait request stuck");
    a_idle_ctrl_off: assert property (!busy |-> ext_pins.chip_select_n == 8'hFF && ext_pins.read_strobe_n
        && ext_pins.write_strobe_n == 4'hF && ext_pins.data_oe_n)
        else $error("control active while idle");
    a_dram_pins_free: assert property (!ext_pins.dram_chip_select_n |-> ext_pins.addr[25:18] == 8'h00
        && !ext_pins.addr[15] && !ext_pins.addr[12] && ext_pins.addr[1:0] == 2'h0
        && ext_pins.write_strobe_n[0] && ext_pins.write_strobe_n[2])
        else $error("static-only pin moved in DRAM access");
    a_dram_cs_shared: assert property (!ext_pins.dram_chip_select_n |-> !ext_pins.chip_select_n[1])
        else $error("select 1 not following DRAM select");
    a_nand_oe_pair: assert property (!ext_pins.nand_out_enable_n |-> !ext_pins.nand_select_n
        && !ext_pins.read_strobe_n)
        else $error("NAND output enable without select and read");
    a_nand_we_pair: assert property (!ext_pins.nand_write_enable_n |-> !ext_pins.nand_select_n
        && !ext_pins.write_enable_n)
        else $error("NAND write enable without select and write");
    a_we_from_strobe: assert property (!ext_pins.write_enable_n |-> !ext_pins.write_strobe_n[0])
        else $error("write enable without write strobe 0");
    a_rdata_delay: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |-> rd_data == $past(data_in, 2))
        else $error("read data not two cycles behind pins");
    c_dram_access: cover property (!ext_pins.dram_chip_select_n);
    c_nand_read: cover property (!ext_pins.nand_out_enable_n);
    c_stalled: cover property (busy && wait_req);
endmodule : ebm_pin_mux_props

// ### tb/ebm_ext_mem.sv
// Purpose : External memory model on the far side of the pins.
// Assumes : Wait is a level the bench commands.
// Notes   : A released data bus toggles so stale values never match.
`timescale 1ns/1ps
module ebm_ext_mem (
    input wire logic               clk,
    input wire logic               hold_wait,
    input wire ebm_pkg::ebm_pins_t ext_pins,
    output logic                   ext_wait_n,
    output logic [31:0]            data_in
);
    logic [31:0] float_reg = 32'h0;
    assign ext_wait_n = !hold_wait;
    // Released bus alternates all-zero and all-one, never unknown
    always @(posedge clk)
        float_reg <= ~float_reg;
    assign data_in = !ext_pins.read_strobe_n ? {ext_pins.addr[15:0], ~ext_pins.addr[15:0]} : float_reg;
endmodule : ebm_ext_mem

// ### tb/ebm_pin_mux_test.sv
// Purpose : Self-checking bench of the pin multiplexer.
// Assumes : Inputs change 1 ns after the rising edge.
// Notes   : Far side is the ebm_ext_mem model.
`timescale 1ns/1ps
module ebm_pin_mux_test;
    logic               clk = 1'b0;
    logic               sys_rst = 1'b1;
    logic               cs1_assign_bit = 1'b0;
    logic               cs3_assign_bit = 1'b0;
    logic               word_valid = 1'b0;
    logic               word_ready;
    ebm_pkg::ebm_word_t word_in = '0;
    logic               hold_wait = 1'b0;
    logic               ext_wait_n;
    logic [31:0]        data_in;
    ebm_pkg::ebm_pins_t ext_pins;
    logic               wait_req;
    logic [31:0]        rd_data;
    logic               busy;
    int                 n_errors = 0;
    int                 cmp_count = 0;

    always #2.5 clk = ~clk;

    ebm_pin_mux dut (.clk(clk), .sys_rst(sys_rst), .cs1_assign_bit(cs1_assign_bit),
        .cs3_assign_bit(cs3_assign_bit), .word_valid(word_valid), .word_ready(word_ready), .word_in(word_in),
        .ext_wait_n(ext_wait_n), .data_in(data_in), .ext_pins(ext_pins), .wait_req(wait_req),
        .rd_data(rd_data), .busy(busy));
    ebm_ext_mem mem (.clk(clk), .hold_wait(hold_wait), .ext_pins(ext_pins), .ext_wait_n(ext_wait_n),
        .data_in(data_in));

    // ********************************
    // Shared tasks
    // ********************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("FAIL %0t %s: got %0h want %0h", $time, what, seen, exp);
        end
    endtask : check

    function automatic ebm_pkg::ebm_word_t mk(input logic owner, input logic [25:0] a);
        ebm_pkg::ebm_word_t w;
        w = '1;
        w.owner = owner;
        w.smc_addr = a;
        w.wdata = {a[15:0], 16'hC3A5};
        return w;
    endfunction : mk

    // Called 1 ns after an edge; holds valid until accepted
    task automatic send(input ebm_pkg::ebm_word_t w, input bit keep = 1'b0);
        word_in = w;
        word_valid = 1'b1;
        while (!word_ready)
        begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        if (!keep)
            word_valid = 1'b0;
    endtask : send

    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 40)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (busy !== lvl)
        begin
            n_errors++;
            $display("FAIL %0t busy wait timed out", $time);
        end
    endtask : wait_busy

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    // ********************************
    // Scenarios
    // ********************************
    task automatic t_static;
        ebm_pkg::ebm_word_t w;
        w = mk(ebm_pkg::OWNER_STATIC, 26'h3C9_A5F3);
        w.cs_n = 8'hFE;
        w.wr_n = 4'hC;
        w.drive = 1'b1;
        w.card_ce_n = 2'h1;
        w.card_io_rd_n = 1'b0;
        w.card_rnw = 1'b0;
        send(w);
        wait_busy(1'b1);
        check(32'(ext_pins.addr), 32'(w.smc_addr), "static addr");
        check(ext_pins.data_out, w.wdata, "data out");
        check(32'(ext_pins.data_oe_n), 32'h0, "data drive");
        check(32'(ext_pins.chip_select_n), 32'hFE, "select");
        check(32'(ext_pins.write_strobe_n), 32'hC, "strobes");
        check(32'(ext_pins.write_enable_n), 32'h0, "write enable");
        check(32'({ext_pins.card_chip_enable_n, ext_pins.card_io_read_n, ext_pins.card_io_write_n,
            ext_pins.card_read_not_write}), 32'hA, "card pins");
        wait_busy(1'b0);
        check(32'(ext_pins === ebm_pkg::PINS_IDLE), 32'h1, "idle after access");
        $display("static test done");
    endtask : t_static

    task automatic t_dram;
        ebm_pkg::ebm_word_t w;
        logic [25:0]        e;
        cs1_assign_bit = 1'b1;
        w = mk(ebm_pkg::OWNER_DRAM, 26'h3FF_FFFF);
        w.dram_addr = 13'h1ABC;
        w.dram_bank = 2'h2;
        w.bm_n = 4'h5;
        w.dram_cs_n = 1'b0;
        w.ras_n = 1'b0;
        w.sdwe_n = 1'b0;
        e = 26'h0;
        e[11:2] = w.dram_addr[9:0];
        e[14:13] = w.dram_addr[12:11];
        e[17:16] = w.dram_bank;
        send(w);
        wait_busy(1'b1);
        check(32'(ext_pins.addr), 32'(e), "dram addr");
        check(32'(ext_pins.dram_addr_ten_pin), 32'(w.dram_addr[10]), "addr ten");
        check(32'(ext_pins.write_strobe_n), {28'h0, w.bm_n[3], 1'b1, w.bm_n[1], 1'b1}, "masks");
        check(32'({ext_pins.dram_chip_select_n, ext_pins.chip_select_n[1]}), 32'h0, "dram select");
        check(32'({ext_pins.ras_n, ext_pins.cas_n, ext_pins.dram_we_n, ext_pins.dram_clock_enable}),
            32'h5, "dram strobes");
        w = mk(ebm_pkg::OWNER_STATIC, 26'h155_0ABC);
        w.cs_n = 8'hFD;
        send(w);
        wait_busy(1'b1);
        check(32'(ext_pins.addr), 32'(w.smc_addr), "owner switch");
        check(32'(ext_pins.chip_select_n[1]), 32'h1, "select 1 kept off");
        wait_busy(1'b0);
        cs1_assign_bit = 1'b0;
        $display("dram test done");
    endtask : t_dram

    task automatic t_nand;
        ebm_pkg::ebm_word_t w;
        for (int i = 0; i < 2; i++)
        begin
            cs3_assign_bit = i[0];
            w = mk(ebm_pkg::OWNER_STATIC, 26'h012_3456);
            w.cs_n = 8'hF7;
            w.rd_n = 1'b0;
            w.drive = 1'b0;
            send(w);
            wait_busy(1'b1);
            check(32'({ext_pins.nand_select_n, ext_pins.nand_out_enable_n}), {30'h0, {2{~i[0]}}}, "nand");
            check(32'(ext_pins.nand_write_enable_n), 32'h1, "nand write");
            // Read data stands for one cycle, two edges after the pop
            repeat (2) @(posedge clk);
            #1;
            check(rd_data, {w.smc_addr[15:0], ~w.smc_addr[15:0]}, "read data");
            wait_busy(1'b0);
        end
        cs3_assign_bit = 1'b0;
        $display("nand test done");
    endtask : t_nand

    task automatic t_wait_fill;
        ebm_pkg::ebm_word_t w;
        w = mk(ebm_pkg::OWNER_STATIC, 26'h2AA_0001);
        w.last = 1'b0;
        send(w);
        wait_busy(1'b1);
        hold_wait = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check(32'(wait_req), 32'h1, "wait seen");
        for (int i = 0; i < 8; i++)
        begin
            w = mk(ebm_pkg::OWNER_STATIC, 26'h2AA_0010 + 26'(i));
            w.last = (i == 7);
            send(w, i < 7);
        end
        check(32'(ext_pins.addr), 32'h2AA_0001, "stalled pins hold");
        check(32'(word_ready), 32'h0, "fifo full");
        hold_wait = 1'b0;
        wait_busy(1'b0);
        check(32'({busy, word_ready}), 32'h1, "drained");
        $display("wait and fill test done");
    endtask : t_wait_fill

    initial
    begin
        repeat (2) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        @(posedge clk);
        #1;
        check(32'({ext_pins === ebm_pkg::PINS_IDLE, busy, word_ready}), 32'h5, "reset state");
        t_static();
        t_dram();
        t_nand();
        t_wait_fill();
        print_verdict();
    end

    initial
    begin
        #(5.0 * 2000);
        n_errors++;
        $display("FAIL %0t watchdog expired", $time);
        print_verdict();
    end
endmodule : ebm_pin_mux_test

bind ebm_pin_mux ebm_pin_mux_props u_props (.clk, .sys_rst, .ext_wait_n, .data_in, .ext_pins, .wait_req,
    .rd_data, .busy);
